// File: core/scan_frame_regs.vh
// Constants for the scan frame assembler: frame layout, timing and serial framing
`ifndef SCAN_FRAME_REGS_VH
`define SCAN_FRAME_REGS_VH
`define FRAME_BYTES 6'h24
`define FRAME_LAST 6'h23
`define IDX_COMP_HI 6'h00
`define IDX_COMP_LO 6'h01
`define IDX_COUNT 6'h02
`define IDX_FREQ_FIRST 6'h03
`define IDX_FREQ_LAST 6'h11
`define IDX_ADC_FIRST 6'h12
`define IDX_ADC_LAST 6'h1D
`define IDX_PAR_COUNT 6'h23
`define FREQ_CHANNELS 3'h5
`define ADC_CHANNELS 4'h8
`define STATUS_BITS 4
`define CLK_HZ 100000000
`define SCANS_PER_SEC 24
`define SCAN_CYCLES (`CLK_HZ / `SCANS_PER_SEC)
`define ADC_SLOT_US 50
`define ADC_SLOT_CYCLES ((`CLK_HZ / 1000000) * `ADC_SLOT_US)
`define NMEA_BAUD 4800
`define NMEA_BIT_CYCLES (`CLK_HZ / `NMEA_BAUD)
`define NMEA_DATA_BITS 4'h8
`define NMEA_START_CHAR 8'h24
`define NMEA_END_CHAR 8'h0A
`define NMEA_MAX_LEN 8'h52
`endif

// File: core/adc_sequencer.v
// Steps the eight converter channels one after another from the start of a scan
`timescale 1ns/10ps
`default_nettype none
`include "scan_frame_regs.vh"
module adc_sequencer #(
   parameter SLOT_CYCLES = `ADC_SLOT_CYCLES
) (
   // Clock and reset
   input wire ref_clk,
   input wire srst,
   // Scan timing
   input wire scanStart,
   // Converter control
   output reg [2:0] adcChannel,
   output reg adcConvert,
   output reg adcBusy
);
   reg [15:0] slotCount_reg;
   reg [2:0] chanNext;
   always @(posedge ref_clk) begin
      if (srst) begin
         slotCount_reg <= 16'h0000;
         adcChannel <= 3'h0;
         adcConvert <= 1'b0;
         adcBusy <= 1'b0;
      end else begin
         adcConvert <= 1'b0;
         if (scanStart) begin
            // First channel begins with the scan itself
            adcChannel <= 3'h0;
            adcConvert <= 1'b1;
            adcBusy <= 1'b1;
            slotCount_reg <= 16'h0000;
         end else if (adcBusy) begin
            if (slotCount_reg == SLOT_CYCLES[15:0] - 16'h0001) begin
               slotCount_reg <= 16'h0000;
               if (adcChannel == 3'h7) begin
                  adcBusy <= 1'b0;
               end else begin
                  adcChannel <= chanNext;
                  adcConvert <= 1'b1;
               end
            end else begin
               slotCount_reg <= slotCount_reg + 16'h0001;
            end
         end
      end
   end
   always @* begin
      chanNext = adcChannel + 3'h1;
   end
endmodule // adc_sequencer
`default_nettype wire

// File: core/nmea_receiver.v
// 4800 baud 8N1 receiver that pulses once per complete position message
`timescale 1ns/10ps
`default_nettype none
`include "scan_frame_regs.vh"
module nmea_receiver #(
   parameter BIT_CYCLES = `NMEA_BIT_CYCLES
) (
   // Clock and reset
   input wire ref_clk,
   input wire srst,
   // Serial line, already synchronised
   input wire rxLine,
   // Results
   output reg [7:0] rxByte,
   output reg rxValid,
   output reg msgPulse
);
   localparam IDLE = 2'h0;
   localparam START = 2'h1;
   localparam DATA = 2'h2;
   localparam STOP = 2'h3;
   reg [1:0] state_reg;
   reg [15:0] tick_reg;
   reg [2:0] bitIdx_reg;
   reg [7:0] shift_reg;
   reg inMsg_reg;
   reg [7:0] msgLen_reg;
   always @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= IDLE;
         tick_reg <= 16'h0000;
         bitIdx_reg <= 3'h0;
         shift_reg <= 8'h00;
         rxByte <= 8'h00;
         rxValid <= 1'b0;
         msgPulse <= 1'b0;
         inMsg_reg <= 1'b0;
         msgLen_reg <= 8'h00;
      end else begin
         rxValid <= 1'b0;
         msgPulse <= 1'b0;
         case (state_reg)
            IDLE: begin
               tick_reg <= 16'h0000;
               if (!rxLine) begin
                  state_reg <= START;
               end
            end
            START: begin
               // Recheck at mid bit to reject glitches
               if (tick_reg == BIT_CYCLES[16:1] - 16'h0001) begin
                  tick_reg <= 16'h0000;
                  bitIdx_reg <= 3'h0;
                  state_reg <= rxLine ? IDLE : DATA;
               end else begin
                  tick_reg <= tick_reg + 16'h0001;
               end
            end
            DATA: begin
               if (tick_reg == BIT_CYCLES[15:0] - 16'h0001) begin
                  tick_reg <= 16'h0000;
                  shift_reg <= {rxLine, shift_reg[7:1]};
                  bitIdx_reg <= bitIdx_reg + 3'h1;
                  if (bitIdx_reg == 3'h7) begin
                     state_reg <= STOP;
                  end
               end else begin
                  tick_reg <= tick_reg + 16'h0001;
               end
            end
            STOP: begin
               if (tick_reg == BIT_CYCLES[15:0] - 16'h0001) begin
                  tick_reg <= 16'h0000;
                  state_reg <= IDLE;
                  // A low stop bit is a framing error; the byte is dropped
                  if (rxLine) begin
                     rxByte <= shift_reg;
                     rxValid <= 1'b1;
                     if (shift_reg == `NMEA_START_CHAR) begin
                        inMsg_reg <= 1'b1;
                        msgLen_reg <= 8'h00;
                     end else if (inMsg_reg && shift_reg == `NMEA_END_CHAR) begin
                        inMsg_reg <= 1'b0;
                        msgPulse <= 1'b1;
                     end else if (inMsg_reg) begin
                        msgLen_reg <= msgLen_reg + 8'h01;
                        if (msgLen_reg == `NMEA_MAX_LEN) begin
                           inMsg_reg <= 1'b0;
                        end
                     end
                  end else begin
                     inMsg_reg <= 1'b0;
                  end
               end else begin
                  tick_reg <= tick_reg + 16'h0001;
               end
            end
            default: begin
               state_reg <= IDLE;
            end
         endcase
      end
   end
endmodule // nmea_receiver
`default_nettype wire

// File: core/ctd_scan_frame_assembler.v
// Scan frame assembler: 36-byte encoder frame, parallel port reorder, position receiver
// Functional notes
// - Every scan starts one 36-byte frame in a fixed order; a frame not drained by the next scan is cut short.
// - Byte 1 is the upper eight bits of the 12-bit pressure compensation value.
// - Byte 2 is the low four compensation bits followed by the status flags.
// - Byte 3 is a scan counter that steps by one per scan and wraps.
// - Next come the five frequency results as fifteen bytes, three per channel.
// - Frequency channels go in order zero to four, bytes 4-6 through 16-18.
// - Bytes 19 to 30 hold the eight 12-bit converter results in channel order.
// - Two consecutive 12-bit converter results share exactly three bytes.
// - The parallel port copy of a scan moves the counter byte to the end.
// - The position receiver runs at 4800 baud, 8 data bits, 1 stop, no parity.
// - The position indicator pulses once per completely decoded message.
// - Frames are produced at a fixed 24 scans per second.
// - Converter channels are taken in turn from scan start, about 50 us each.
`timescale 1ns/10ps
`default_nettype none
`include "scan_frame_regs.vh"
module ctd_scan_frame_assembler #(
   parameter SCAN_CYCLES = `SCAN_CYCLES,
   parameter SLOT_CYCLES = `ADC_SLOT_CYCLES,
   parameter BIT_CYCLES = `NMEA_BIT_CYCLES
) (
   // Clock and reset
   input wire ref_clk,
   input wire srst,
   // Channel values from the counting and conversion logic
   input wire [11:0] compValue,
   input wire [3:0] statusFlags,
   input wire [119:0] freqWords,
   input wire [95:0] adcWords,
   // Converter sequencing
   output wire [2:0] adcChannel,
   output wire adcConvert,
   // Encoder byte stream
   output reg [7:0] encData,
   output reg encValid,
   input wire encReady,
   output reg encFirst,
   output reg encLast,
   // Parallel instrument port byte stream
   output reg [7:0] parData,
   output reg parValid,
   input wire parReady,
   output reg parLast,
   // Scan timing
   output reg scanStart,
   output reg overrun,
   // Position receiver pin and indicator
   input wire nmeaRx,
   output wire [7:0] nmeaByte,
   output wire nmeaByteValid,
   output wire nmeaLed
);
   reg [31:0] scanCount_reg;
   reg [7:0] modCount_reg;
   reg [11:0] compSnap_reg;
   reg [3:0] statusSnap_reg;
   reg [119:0] freqSnap_reg;
   reg [95:0] adcSnap_reg;
   reg [5:0] encIdx_reg;
   reg encBusy_reg;
   reg [5:0] parIdx_reg;
   reg parBusy_reg;
   reg rxMeta_reg;
   reg rxSync_reg;
   reg [7:0] encByte;
   wire [7:0] parByte;
   wire [5:0] parSrc;
   reg [31:0] scanCount_next;
   reg scanWrap;
   reg [5:0] encIdx_next;
   reg encBusy_next;
   reg encAccept;
   reg encLoad;
   reg [5:0] parIdx_next;
   reg parBusy_next;
   reg parAccept;

   // Returns frame byte idx (zero based) from the snapshot
   function [7:0] frame_byte;
      input [5:0] idx;
      input [11:0] comp;
      input [3:0] stat;
      input [7:0] cnt;
      input [119:0] freq;
      input [95:0] adc;
      reg [5:0] off;
      reg [6:0] bitPos;
      begin
         off = 6'h00;
         bitPos = 7'h00;
         if (idx == `IDX_COMP_HI) begin
            frame_byte = comp[11:4];
         end else if (idx == `IDX_COMP_LO) begin
            frame_byte = {comp[3:0], stat};
         end else if (idx == `IDX_COUNT) begin
            frame_byte = cnt;
         end else if (idx <= `IDX_FREQ_LAST) begin
            // Channel 0 first, each word most significant byte first
            off = idx - `IDX_FREQ_FIRST;
            bitPos = 7'h77 - {off[3:0], 3'h0};
            frame_byte = freq[bitPos -: 8];
         end else if (idx <= `IDX_ADC_LAST) begin
            // Channel pairs packed as 24 bits, lower channel in the high bits
            off = idx - `IDX_ADC_FIRST;
            bitPos = 7'h5F - {off[3:0], 3'h0};
            frame_byte = adc[bitPos -: 8];
         end else begin
            frame_byte = 8'h00;
         end
      end
   endfunction

   // Parallel slot to frame index: 0,1 stay, 2..34 take 3..35, slot 35 is the counter
   function [5:0] par_source;
      input [5:0] slot;
      begin
         if (slot == `IDX_PAR_COUNT) begin
            par_source = `IDX_COUNT;
         end else if (slot < `IDX_COUNT) begin
            par_source = slot;
         end else begin
            par_source = slot + 6'h01;
         end
      end
   endfunction

   // Scan pacing; frame restarts are self-timed, not from any outside strobe
   always @* begin
      scanWrap = (scanCount_reg == SCAN_CYCLES - 1);
      if (scanWrap) begin
         scanCount_next = 32'h00000000;
      end else begin
         scanCount_next = scanCount_reg + 32'h00000001;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         scanCount_reg <= 32'h00000000;
         scanStart <= 1'b0;
      end else begin
         scanCount_reg <= scanCount_next;
         scanStart <= scanWrap;
      end
   end

   adc_sequencer #(
      .SLOT_CYCLES(SLOT_CYCLES)
   ) u_adc_sequencer (
      .ref_clk(ref_clk),
      .srst(srst),
      .scanStart(scanStart),
      .adcChannel(adcChannel),
      .adcConvert(adcConvert),
      .adcBusy()
   );

   // Snapshot at scan start so a frame never mixes two scans
   always @(posedge ref_clk) begin
      if (srst) begin
         modCount_reg <= 8'hFF;
         compSnap_reg <= 12'h000;
         statusSnap_reg <= 4'h0;
         freqSnap_reg <= 120'h0;
         adcSnap_reg <= 96'h0;
         overrun <= 1'b0;
      end else if (scanStart) begin
         // The previous frame must be drained; if not it is cut short
         // Cutting keeps each frame tied to one scan; a slow sink loses bytes, not timing
         overrun <= encBusy_reg | parBusy_reg;
         modCount_reg <= modCount_reg + 8'h01;
         compSnap_reg <= compValue;
         statusSnap_reg <= statusFlags;
         freqSnap_reg <= freqWords;
         adcSnap_reg <= adcWords;
      end else begin
         overrun <= 1'b0;
      end
   end

   // Encoder stream: indices 0..35 once per scan
   always @* begin
      encAccept = encBusy_reg && encReady;
      encLoad = scanStart || (encAccept && encIdx_reg != `FRAME_LAST);
      encIdx_next = encIdx_reg;
      encBusy_next = encBusy_reg;
      if (scanStart) begin
         encIdx_next = 6'h00;
         encBusy_next = 1'b1;
      end else if (encAccept) begin
         if (encIdx_reg == `FRAME_LAST) begin
            encBusy_next = 1'b0;
         end else begin
            encIdx_next = encIdx_reg + 6'h01;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         encIdx_reg <= 6'h00;
         encBusy_reg <= 1'b0;
      end else begin
         encIdx_reg <= encIdx_next;
         encBusy_reg <= encBusy_next;
      end
   end

   // At scan start the snapshot lands on this same edge, so the first byte comes from
   // the live inputs instead
   always @* begin
      if (scanStart) begin
         encByte = frame_byte(6'h00, compValue, statusFlags, modCount_reg + 8'h01,
            freqWords, adcWords);
      end else begin
         encByte = frame_byte(encIdx_reg + 6'h01, compSnap_reg, statusSnap_reg,
            modCount_reg, freqSnap_reg, adcSnap_reg);
      end
   end

   // Output holding register reloaded from the walking index only at scan start or when a byte is accepted
   always @(posedge ref_clk) begin
      if (srst) begin
         encData <= 8'h00;
         encValid <= 1'b0;
         encFirst <= 1'b0;
         encLast <= 1'b0;
      end else if (encLoad) begin
         encValid <= 1'b1;
         encData <= encByte;
         encFirst <= scanStart;
         encLast <= !scanStart && (encIdx_reg + 6'h01 == `FRAME_LAST);
      end else if (encAccept) begin
         encValid <= 1'b0;
         encFirst <= 1'b0;
         encLast <= 1'b0;
      end
   end

   // Parallel copy: counter byte skipped at the front and sent last
   always @* begin
      parAccept = parBusy_reg && parReady;
      parIdx_next = parIdx_reg;
      parBusy_next = parBusy_reg;
      if (scanStart) begin
         parIdx_next = 6'h00;
         parBusy_next = 1'b1;
      end else if (parAccept) begin
         if (parIdx_reg == `FRAME_LAST) begin
            parBusy_next = 1'b0;
         end else begin
            parIdx_next = parIdx_reg + 6'h01;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         parIdx_reg <= 6'h00;
         parBusy_reg <= 1'b0;
      end else begin
         parIdx_reg <= parIdx_next;
         parBusy_reg <= parBusy_next;
      end
   end

   // No holding register here: the sink sees the next byte in the cycle the index moves
   assign parSrc = par_source(parIdx_reg);
   assign parByte = frame_byte(parSrc, compSnap_reg, statusSnap_reg, modCount_reg,
      freqSnap_reg, adcSnap_reg);

   always @* begin
      parData = parByte;
      parValid = parBusy_reg;
      parLast = parBusy_reg && (parIdx_reg == `FRAME_LAST);
   end

   // Two-stage synchroniser on the position line pin
   // Both stages reset to the idle level so release never fakes a start bit
   always @(posedge ref_clk) begin
      if (srst) begin
         rxMeta_reg <= 1'b1;
         rxSync_reg <= 1'b1;
      end else begin
         rxMeta_reg <= nmeaRx;
         rxSync_reg <= rxMeta_reg;
      end
   end

   nmea_receiver #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_nmea_receiver (
      .ref_clk(ref_clk),
      .srst(srst),
      .rxLine(rxSync_reg),
      .rxByte(nmeaByte),
      .rxValid(nmeaByteValid),
      .msgPulse(nmeaLed)
   );
endmodule // ctd_scan_frame_assembler
`default_nettype wire

// File: bench/ctd_scan_frame_properties.sv
// Concurrent checks on the scan frame assembler ports
`timescale 1ns/10ps
`default_nettype none
module ctd_scan_frame_properties #(
   parameter int SCAN_CYCLES = 200,
   parameter int SLOT_CYCLES = 4
) (
   // Clock, reset and inputs
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [11:0] compValue,
   input wire logic encReady,
   input wire logic parReady,
   // Outputs
   input wire logic [2:0] adcChannel,
   input wire logic adcConvert,
   input wire logic [7:0] encData,
   input wire logic encValid,
   input wire logic encFirst,
   input wire logic encLast,
   input wire logic parValid,
   input wire logic parLast,
   input wire logic scanStart,
   input wire logic [7:0] nmeaByte,
   input wire logic nmeaLed
);
   logic [31:0] gap;
   logic seen;
   logic cntSeen;
   logic [5:0] encN;
   logic [5:0] parN;
   logic [7:0] prevCnt;
   logic [2:0] prevChan;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Counters restart at every scan so a restarted frame stays aligned
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gap <= 32'h0;
         seen <= 1'b0;
         cntSeen <= 1'b0;
         encN <= 6'h00;
         parN <= 6'h00;
      end else begin
         gap <= scanStart ? 32'h0 : gap + 32'h1;
         seen <= seen | scanStart;
         if (scanStart) encN <= 6'h00;
         else if (encValid && encReady) encN <= encLast ? 6'h00 : encN + 6'h01;
         if (scanStart) parN <= 6'h00;
         else if (parValid && parReady) parN <= parLast ? 6'h00 : parN + 6'h01;
         cntSeen <= cntSeen | (encValid && encReady && encN == 6'h02);
      end
      if (encValid && encReady && encN == 6'h02) prevCnt <= encData;
      if (adcConvert) prevChan <= adcChannel;
   end
   scan_period_a: assert property (scanStart && seen |-> gap == SCAN_CYCLES - 1)
      else $error("scan period wrong");
   first_byte_a: assert property (scanStart |=> encValid && encFirst &&
      encData == $past(compValue[11:4])) else $error("first byte wrong");
   frame_len_a: assert property (encValid && encReady && encLast |-> encN == 6'h23)
      else $error("frame length wrong");
   byte_hold_a: assert property (encValid && !encReady && !scanStart |=>
      encValid && $stable(encData)) else $error("byte not held");
   scan_count_a: assert property (encValid && encReady && encN == 6'h02 && cntSeen
      |-> encData == prevCnt + 8'h01) else $error("count step wrong");
   zero_tail_a: assert property (encValid && encN >= 6'h1E |-> encData == 8'h00)
      else $error("expansion byte not zero");
   par_len_a: assert property (parValid && parReady && parLast |-> parN == 6'h23)
      else $error("parallel length wrong");
   adc_first_a: assert property (scanStart |=> adcConvert && adcChannel == 3'h0)
      else $error("first channel wrong");
   adc_step_a: assert property (adcConvert && adcChannel != 3'h7 |-> ##SLOT_CYCLES
      adcConvert && adcChannel == prevChan + 3'h1) else $error("channel step wrong");
   led_pulse_a: assert property (nmeaLed |-> nmeaByte == 8'h0A ##1 !nmeaLed)
      else $error("indicator pulse wrong");
endmodule // ctd_scan_frame_properties
bind ctd_scan_frame_assembler ctd_scan_frame_properties #(
   .SCAN_CYCLES(SCAN_CYCLES),
   .SLOT_CYCLES(SLOT_CYCLES)
) u_props (
   .ref_clk(ref_clk), .srst(srst), .compValue(compValue), .encReady(encReady),
   .parReady(parReady), .adcChannel(adcChannel), .adcConvert(adcConvert),
   .encData(encData), .encValid(encValid), .encFirst(encFirst), .encLast(encLast),
   .parValid(parValid), .parLast(parLast), .scanStart(scanStart),
   .nmeaByte(nmeaByte), .nmeaLed(nmeaLed)
);
`default_nettype wire

// File: bench/deck_sink.sv
// Deck unit receiver model taking encoder and parallel bytes
`timescale 1ns/10ps
`default_nettype none
module deck_sink (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Stall mode
   input wire logic stall,
   // Encoder stream
   input wire logic encValid,
   input wire logic encLast,
   output logic encReady,
   // Parallel stream
   input wire logic parValid,
   input wire logic parLast,
   output logic parReady
);
   int encFrames = 0;
   int parFrames = 0;
   // Random gaps stand for a busy processor; never ready while in reset
   always @(negedge ref_clk) begin
      encReady <= !srst && (!stall || $urandom_range(1));
      parReady <= !srst && (!stall || $urandom_range(1));
   end
   always @(posedge ref_clk) begin
      if (encValid && encReady && encLast) encFrames <= encFrames + 1;
      if (parValid && parReady && parLast) parFrames <= parFrames + 1;
   end
endmodule // deck_sink
`default_nettype wire

// File: bench/ctd_scan_frame_assembler_tb.sv
// Self-checking bench for the scan frame assembler
`timescale 1ns/10ps
`default_nettype none
module ctd_scan_frame_assembler_tb;
   localparam int SCAN = 200;
   localparam int BITC = 16;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [11:0] compValue = 12'h000;
   logic [3:0] statusFlags = 4'h0;
   logic [119:0] freqWords = '0;
   logic [95:0] adcWords = '0;
   logic nmeaRx = 1'b1;
   logic stall = 1'b0;
   logic encReady, parReady, adcConvert, encValid, encFirst, encLast;
   logic parValid, parLast, scanStart, overrun, nmeaByteValid, nmeaLed;
   logic [2:0] adcChannel;
   logic [7:0] encData, parData, nmeaByte;
   logic [7:0] cntModel = 8'h00;
   logic ovExp = 1'b0;
   logic [127:0] r128;
   logic [7:0] encExp[$], parExp[$], nmeaExp[$];
   int n_mismatch = 0, check_count = 0, encI = 0, parI = 0, nScan = 0, ledN = 0;
   always #5 ref_clk = ~ref_clk;
   ctd_scan_frame_assembler #(.SCAN_CYCLES(SCAN), .SLOT_CYCLES(4), .BIT_CYCLES(BITC))
   u_ctd_scan_frame_assembler (
      .ref_clk(ref_clk), .srst(srst), .compValue(compValue), .statusFlags(statusFlags),
      .freqWords(freqWords), .adcWords(adcWords), .adcChannel(adcChannel),
      .adcConvert(adcConvert), .encData(encData), .encValid(encValid),
      .encReady(encReady), .encFirst(encFirst), .encLast(encLast), .parData(parData),
      .parValid(parValid), .parReady(parReady), .parLast(parLast),
      .scanStart(scanStart), .overrun(overrun), .nmeaRx(nmeaRx), .nmeaByte(nmeaByte),
      .nmeaByteValid(nmeaByteValid), .nmeaLed(nmeaLed)
   );
   deck_sink u_deck_sink (
      .ref_clk(ref_clk), .srst(srst), .stall(stall), .encValid(encValid),
      .encLast(encLast), .encReady(encReady), .parValid(parValid), .parLast(parLast),
      .parReady(parReady)
   );
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Reference frame built from the values the design sees at scan start
   task automatic add_frame();
      logic [287:0] f;
      f = {compValue, statusFlags, cntModel, freqWords, adcWords, 48'h0};
      for (int i = 0; i < 36; i++) encExp.push_back(f[287 - 8 * i -: 8]);
      for (int i = 0; i < 36; i++) if (i != 2) parExp.push_back(f[287 - 8 * i -: 8]);
      parExp.push_back(cntModel);
      cntModel = cntModel + 8'h01;
   endtask
   task automatic new_values(input int s);
      @(negedge ref_clk);
      r128 = {$urandom, $urandom, $urandom, $urandom};
      compValue <= (s == 0) ? 12'hFFF : r128[11:0];
      statusFlags <= (s == 0) ? 4'hF : r128[15:12];
      freqWords <= (s == 0) ? '1 : r128[119:0];
      adcWords <= (s == 0) ? '1 : {r128[63:0], r128[127:96]};
   endtask
   task automatic wait_drain(input int n);
      for (int i = 0; i < 2 * SCAN; i++) begin
         @(negedge ref_clk);
         if (nScan >= n && encExp.size() == 0 && parExp.size() == 0) return;
      end
      n_mismatch++;
      $display("wrong value drain expected 0 seen %0d", encExp.size());
      end_sim();
   endtask
   task automatic send_char(input logic [7:0] c);
      logic [9:0] w;
      w = {1'b1, c, 1'b0};
      nmeaExp.push_back(c);
      for (int b = 0; b < 10; b++) begin
         nmeaRx <= w[b];
         repeat (BITC) @(negedge ref_clk);
      end
   endtask
   always @(posedge ref_clk) begin
      if (srst === 1'b0) check("overrun", ovExp, overrun);
      ovExp = (scanStart === 1'b1) && (encExp.size() != 0 || parExp.size() != 0);
      if (scanStart === 1'b1) begin
         nScan++;
         add_frame();
      end
      if (encValid === 1'b1 && encReady) begin
         check("enc marks", {encI == 0, encI == 35}, {encFirst, encLast});
         if (encI < 3) check("enc head", encExp.pop_front(), encData);
         else if (encI < 18) check("enc freq", encExp.pop_front(), encData);
         else if (encI < 30) check("enc adc", encExp.pop_front(), encData);
         else check("enc tail", encExp.pop_front(), encData);
         encI = (encI == 35) ? 0 : encI + 1;
      end
      if (parValid === 1'b1 && parReady) begin
         check("par byte", parExp.pop_front(), parData);
         check("par last", parI == 35, parLast);
         parI = (parI == 35) ? 0 : parI + 1;
      end
      if (nmeaByteValid === 1'b1) check("nmea byte", nmeaExp.pop_front(), nmeaByte);
      if (nmeaLed === 1'b1) ledN++;
   end
   initial begin
      void'($urandom(32'h202e));
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      srst <= 1'b0;
      fork
         begin
            for (int s = 0; s < 8; s++) begin
               new_values(s);
               stall <= s[0];
               wait_drain(s + 1);
            end
            check("sink frames", nScan, u_deck_sink.encFrames);
            check("par frames", nScan, u_deck_sink.parFrames);
         end
         begin
            @(negedge ref_clk);
            send_char(8'h24);
            repeat (3) send_char(8'h30 + 8'($urandom_range(42)));
            send_char(8'h0A);
            send_char(8'h5A);
            send_char(8'h0A);
            send_char(8'h24);
            send_char(8'h51);
            send_char(8'h0A);
            repeat (4 * BITC) @(negedge ref_clk);
         end
      join
      check("led pulses", 2, ledN);
      end_sim();
   end
endmodule // ctd_scan_frame_assembler_tb
`default_nettype wire
